/* File: logic/bdm_data_memory.v */
/*
  banked data memory with indirect windows, bank select, pc low,
  table high byte and status flags.
  assumes the core asserts at most one of memRd/memWr per cycle and
  drives alu flag results with aluWb when a result is written back.
*/
`timescale 1ns/1ps
`include "bdm_map.vh"

// Operation
// - every bank is eight bits wide, addresses start at zero
// - special registers in every bank; eeprom control only in bank one
// - bank four locations 80h to 95h drive the display contents
// - unused special locations read zero
// - window access goes to the location held in its pointer
// - first pair reaches bank zero, second pair uses bank select
// - window addressed through a window reads zero, write ignored
// - direct accesses always hit bank zero
// - five banks, three bit field, upper bits read zero
// - reset clears bank select except watchdog reset while asleep
// - writing pc low jumps within page with one dummy cycle
// - table read loads high byte; table pointers freely adjustable
// - status writes change arithmetic flags, never timeout or powerdown
// - carry set on add carry or no subtract borrow, rotate too
// - nibble carry set on low nibble carry or no borrow
// - zero flag set when result is zero
// - overflow set when carry into and out of msb differ
// - powerdown cleared by power-up or watchdog clear, set by halt
// - timeout cleared by power-up, watchdog clear or halt; set by expiry
// - status is never pushed automatically on interrupt or call
// - status bits: to5 pdf4 ov3 z2 ac1 c0, bits 7:6 zero
module bdm_data_memory #(
  parameter NUM_BANKS = 5,
  parameter LCD_SIZE  = 22
) (
  input  wire       mclk,
  input  wire       nrst,
  input  wire       wdtSleepRst,
  input  wire [7:0] memAddr,
  input  wire       memRd,
  input  wire       memWr,
  input  wire [7:0] memWrData,
  output reg  [7:0] memRdData,
  input  wire       aluWb,
  input  wire       aluFlagEn,
  input  wire       aluCarryEn,
  input  wire       aluCarry,
  input  wire       aluNibbleCarry,
  input  wire       aluZero,
  input  wire       aluOverflow,
  input  wire       haltInstr,
  input  wire       watchdogClearInstr,
  input  wire       watchdogExpired,
  input  wire       tableLoad,
  input  wire [7:0] tableHighIn,
  input  wire [7:0] accIn,
  input  wire       accLoad,
  output reg  [7:0] accumulatorReg,
  output reg  [7:0] pointerZero,
  output reg  [7:0] pointerOne,
  output wire [7:0] dataBankSelect,
  output reg  [7:0] programCounterLow,
  output reg        pcJump,
  output reg        dummyCycle,
  output reg  [7:0] tableLowPtr,
  output reg  [7:0] tableHighPtr,
  output reg  [7:0] tableHighByte,
  output wire [7:0] statusReg,
  output reg  [`BDM_EEC_WIDTH-1:0] eepromControlReg,
  output reg        lcdWr,
  output reg  [4:0] lcdAddr,
  output reg  [7:0] lcdData
);
  reg  [2:0] bankField_r;
  reg        watchdogExpiredFlag_r;
  reg        poweredDownFlag_r;
  reg        signedOverflowFlag_r;
  reg        zeroFlag_r;
  reg        nibbleCarryFlag_r;
  reg        carryFlag_r;

  // effective address resolution
  reg  [7:0] effAddr;
  reg  [2:0] effBank;
  reg        nullAccess;
  wire       isWin0 = (memAddr == `BDM_OFF_WIN0);
  wire       isWin1 = (memAddr == `BDM_OFF_WIN1);

  always @* begin
    effAddr    = memAddr;
    effBank    = 3'h0;
    nullAccess = 1'b0;
    if (isWin0) begin
      effAddr = pointerZero;
      effBank = 3'h0;
    end else if (isWin1) begin
      effAddr = pointerOne;
      effBank = bankField_r;
    end
    if ((isWin0 || isWin1) && (effAddr == `BDM_OFF_WIN0 ||
        effAddr == `BDM_OFF_WIN1)) begin
      nullAccess = 1'b1;
    end
  end

  wire isGp    = effAddr[7];
  wire bankOk  = (effBank <= `BDM_MAX_BANK);
  wire isLcd   = isGp && (effBank == `BDM_LCD_BANK) &&
                 (effAddr <= `BDM_LCD_LAST);
  wire doWr    = memWr && !nullAccess;
  wire sfrWr   = doWr && !isGp;
  wire eecSel  = (effAddr == `BDM_OFF_EECTRL) &&
                 (effBank == `BDM_EEC_BANK);

  // general purpose banks, one array per bank
  wire [7:0] bankRd [0:NUM_BANKS-1];
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g = g + 1) begin : gBank
      bdm_gp_bank #(
        .DEPTH (128),
        .AW    (7)
      ) uBank (
        .mclk   (mclk),
        .wrEn   (doWr && isGp && (effBank == g)),
        .addr   (effAddr[6:0]),
        .wrData (memWrData),
        .rdData (bankRd[g])
      );
    end
  endgenerate

  assign dataBankSelect = {5'h00, bankField_r};
  assign statusReg = {2'b00, watchdogExpiredFlag_r, poweredDownFlag_r,
                      signedOverflowFlag_r, zeroFlag_r,
                      nibbleCarryFlag_r, carryFlag_r};

  // read mux
  always @* begin
    memRdData = 8'h00;
    if (memRd && !nullAccess) begin
      if (isGp) begin
        if (bankOk) begin
          memRdData = bankRd[effBank];
        end
      end else begin
        case (effAddr)
          `BDM_OFF_PTR0:     memRdData = pointerZero;
          `BDM_OFF_PTR1:     memRdData = pointerOne;
          `BDM_OFF_BANKSEL:  memRdData = dataBankSelect;
          `BDM_OFF_ACC:      memRdData = accumulatorReg;
          `BDM_OFF_PCLOW:    memRdData = programCounterLow;
          `BDM_OFF_TBLLO:    memRdData = tableLowPtr;
          `BDM_OFF_TBLHIPTR: memRdData = tableHighPtr;
          `BDM_OFF_TBLHIGH:  memRdData = tableHighByte;
          `BDM_OFF_STATUS:   memRdData = statusReg;
          `BDM_OFF_EECTRL: begin
            if (eecSel) begin
              memRdData = {4'h0, eepromControlReg};
            end
          end
          default:           memRdData = 8'h00;
        endcase
      end
    end
  end

  // a watchdog reset taken while asleep never pulls nrst; the core
  // raises wdtSleepRst instead, so the bank select simply holds
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bankField_r <= `BDM_BANK_RST;
    end else if (wdtSleepRst) begin
      bankField_r <= bankField_r;
    end else if (sfrWr && effAddr == `BDM_OFF_BANKSEL) begin
      bankField_r <= memWrData[2:0];
    end
  end

  // special registers
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pointerZero       <= 8'h00;
      pointerOne        <= 8'h00;
      accumulatorReg    <= 8'h00;
      programCounterLow <= 8'h00;
      pcJump            <= 1'b0;
      dummyCycle        <= 1'b0;
      tableLowPtr       <= 8'h00;
      tableHighPtr      <= 8'h00;
      tableHighByte     <= 8'h00;
      eepromControlReg  <= {`BDM_EEC_WIDTH{1'b0}};
      lcdWr             <= 1'b0;
      lcdAddr           <= 5'h00;
      lcdData           <= 8'h00;
    end else begin
      pcJump     <= 1'b0;
      dummyCycle <= pcJump;
      lcdWr      <= 1'b0;
      if (accLoad) begin
        accumulatorReg <= accIn;
      end
      if (tableLoad) begin
        tableHighByte <= tableHighIn;
      end
      if (doWr && isLcd) begin
        lcdWr   <= 1'b1;
        lcdAddr <= effAddr[4:0];
        lcdData <= memWrData;
      end
      if (sfrWr) begin
        case (effAddr)
          `BDM_OFF_PTR0:     pointerZero <= memWrData;
          `BDM_OFF_PTR1:     pointerOne  <= memWrData;
          `BDM_OFF_ACC: begin
            if (!accLoad) begin
              accumulatorReg <= memWrData;
            end
          end
          `BDM_OFF_PCLOW: begin
            programCounterLow <= memWrData;
            pcJump            <= 1'b1;
          end
          `BDM_OFF_TBLLO:    tableLowPtr  <= memWrData;
          `BDM_OFF_TBLHIPTR: tableHighPtr <= memWrData;
          `BDM_OFF_EECTRL: begin
            if (eecSel) begin
              eepromControlReg <= memWrData[`BDM_EEC_WIDTH-1:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // status flags; there is no stack save path at all
  wire stWr = sfrWr && (effAddr == `BDM_OFF_STATUS);

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      signedOverflowFlag_r <= 1'b0;
      zeroFlag_r           <= 1'b0;
      nibbleCarryFlag_r    <= 1'b0;
      carryFlag_r          <= 1'b0;
    end else if (aluWb && aluFlagEn) begin
      // alu result wins over a software write in the same cycle
      signedOverflowFlag_r <= aluOverflow;
      zeroFlag_r           <= aluZero;
      nibbleCarryFlag_r    <= aluNibbleCarry;
      carryFlag_r          <= aluCarry;
    end else if (aluWb && aluCarryEn) begin
      carryFlag_r          <= aluCarry;
    end else if (stWr) begin
      signedOverflowFlag_r <= memWrData[`BDM_ST_OV];
      zeroFlag_r           <= memWrData[`BDM_ST_Z];
      nibbleCarryFlag_r    <= memWrData[`BDM_ST_AC];
      carryFlag_r          <= memWrData[`BDM_ST_C];
    end
  end

  // system flags ignore status writes entirely
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      poweredDownFlag_r     <= 1'b0;
      watchdogExpiredFlag_r <= 1'b0;
    end else begin
      if (watchdogClearInstr) begin
        poweredDownFlag_r <= 1'b0;
      end else if (haltInstr) begin
        poweredDownFlag_r <= 1'b1;
      end
      // expiry wins over a clear in the same cycle
      if (watchdogExpired) begin
        watchdogExpiredFlag_r <= 1'b1;
      end else if (watchdogClearInstr || haltInstr) begin
        watchdogExpiredFlag_r <= 1'b0;
      end
    end
  end
endmodule // bdm_data_memory

/* File: logic/bdm_map.vh */
/*
  constants for the banked data memory: special register offsets,
  bank codes, status bit positions, reset values.
  assumes a core that issues 8-bit addresses into a 256-byte space.
*/
`ifndef BDM_MAP_VH
`define BDM_MAP_VH

`define BDM_OFF_WIN0      8'h00
`define BDM_OFF_PTR0      8'h01
`define BDM_OFF_WIN1      8'h02
`define BDM_OFF_PTR1      8'h03
`define BDM_OFF_BANKSEL   8'h04
`define BDM_OFF_ACC       8'h05
`define BDM_OFF_PCLOW     8'h06
`define BDM_OFF_TBLLO     8'h07
`define BDM_OFF_TBLHIPTR  8'h08
`define BDM_OFF_TBLHIGH   8'h09
`define BDM_OFF_STATUS    8'h0a
`define BDM_OFF_EECTRL    8'h40

`define BDM_GP_BASE       8'h80
`define BDM_LCD_FIRST     8'h80
`define BDM_LCD_LAST      8'h95
`define BDM_LCD_BANK      3'h4
`define BDM_EEC_BANK      3'h1
`define BDM_MAX_BANK      3'h4

`define BDM_ST_TO         5
`define BDM_ST_PDF        4
`define BDM_ST_OV         3
`define BDM_ST_Z          2
`define BDM_ST_AC         1
`define BDM_ST_C          0

`define BDM_BANK_RST      3'h0
`define BDM_EEC_WIDTH     4

`endif

/* File: logic/bdm_gp_bank.v */
/*
  one bank of general purpose ram, 128 x 8, upper half of the space.
  assumes one access per cycle with a synchronous write; read is
  combinational so the core sees data in the same cycle.
*/
`timescale 1ns/1ps
module bdm_gp_bank #(
  parameter DEPTH = 128,
  parameter AW    = 7
) (
  input  wire          mclk,
  input  wire          wrEn,
  input  wire [AW-1:0] addr,
  input  wire [7:0]    wrData,
  output wire [7:0]    rdData
);
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge mclk) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
  end

  assign rdData = mem[addr];
endmodule // bdm_gp_bank

/* File: dv/bdm_core_model.sv */
/* cpu core model: byte reads and writes on the data memory port.
   assumes the bench clock; requests change only on falling edges. */
`timescale 1ns/1ps
module bdm_core_model (
  input  wire       mclk,
  output reg  [7:0] memAddr,
  output reg        memRd,
  output reg        memWr,
  output reg  [7:0] memWrData,
  input  wire [7:0] memRdData
);
  initial {memAddr, memRd, memWr, memWrData} = 18'h0;
  // released bus shows inverted values so stale data never passes
  task automatic idle();
    {memRd, memWr} = 2'b00;
    memAddr = ~memAddr;
    memWrData = ~memWrData;
  endtask
  task automatic wr(input [7:0] ad, input [7:0] dt);
    @(negedge mclk);
    {memAddr, memWrData, memWr} = {ad, dt, 1'b1};
    @(negedge mclk);
    idle();
  endtask
  task automatic rd(input [7:0] ad, output [7:0] dt);
    @(negedge mclk);
    {memAddr, memRd} = {ad, 1'b1};
    @(posedge mclk) dt = memRdData;
    @(negedge mclk);
    idle();
  endtask
endmodule // bdm_core_model

/* File: dv/bdm_data_memory_sva.sv */
/* port assertions for the banked data memory.
   assumes binding to bdm_data_memory, ports matched by name. */
`timescale 1ns/1ps
`include "bdm_map.vh"
module bdm_data_memory_sva (
  input wire       mclk, nrst, memRd, memWr, aluWb, aluFlagEn, aluCarry,
  input wire       aluNibbleCarry, aluZero, aluOverflow, haltInstr,
  input wire       watchdogClearInstr, watchdogExpired, tableLoad,
  input wire       pcJump, dummyCycle, lcdWr,
  input wire [7:0] memAddr, memWrData, memRdData, tableHighIn, lcdData,
  input wire [7:0] pointerZero, pointerOne, dataBankSelect, statusReg,
  input wire [7:0] tableHighByte,
  input wire [4:0] lcdAddr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire sysEv = haltInstr | watchdogClearInstr | watchdogExpired;
  sequence s_pclWr; memWr && memAddr == `BDM_OFF_PCLOW; endsequence
  sequence s_jump; pcJump ##1 dummyCycle; endsequence
  sequence s_lcdWr;
    memWr && memAddr == `BDM_OFF_WIN1 && dataBankSelect[2:0] == 3'h4 &&
    pointerOne inside {[8'h80:8'h95]};
  endsequence
  property p_st_top; statusReg[7:6] == 2'b00; endproperty
  a_st_top: assert property (p_st_top) else $error("st top");
  property p_bank_wr; memWr && memAddr == `BDM_OFF_BANKSEL &&
    memWrData[2:0] <= 3'h4 |=> dataBankSelect == {5'h00, $past(memWrData[2:0])};
  endproperty
  a_bank_wr: assert property (p_bank_wr) else $error("bank wr");
  property p_st_hold; !sysEv |=> $stable(statusReg[5:4]); endproperty
  a_st_hold: assert property (p_st_hold) else $error("to pdf");
  property p_halt; haltInstr && !watchdogExpired |=> statusReg[5:4] == 2'b01;
  endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_expire; watchdogExpired |=> statusReg[5]; endproperty
  a_expire: assert property (p_expire) else $error("expiry");
  property p_alu; aluWb && aluFlagEn |=> statusReg[3:0] == {$past(aluOverflow),
    $past(aluZero), $past(aluNibbleCarry), $past(aluCarry)};
  endproperty
  a_alu: assert property (p_alu) else $error("alu flags");
  property p_flag_hold; !aluWb && !memWr |=> $stable(statusReg[3:0]);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("hold");
  property p_unused; memRd && memAddr inside {[8'h0b:8'h7f]} |->
    memRdData == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused");
  property p_winwin; memRd && memAddr == `BDM_OFF_WIN0 &&
    pointerZero inside {8'h00, 8'h02} |-> memRdData == 8'h00;
  endproperty
  a_winwin: assert property (p_winwin) else $error("winwin");
  property p_tbl; tableLoad |=> tableHighByte == $past(tableHighIn);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table");
  property p_pcl; s_pclWr |=> s_jump; endproperty
  a_pcl: assert property (p_pcl) else $error("pc jump");
  property p_lcd; s_lcdWr |=> lcdWr && lcdData == $past(memWrData) &&
    lcdAddr == $past(pointerOne[4:0]);
  endproperty
  a_lcd: assert property (p_lcd) else $error("lcd");
endmodule // bdm_data_memory_sva
bind bdm_data_memory bdm_data_memory_sva u_sva (.*);

/* File: dv/tb_top.sv */
/* self-checking bench for the banked data memory.
   assumes bdm_map.vh on the include path and the core model beside. */
`timescale 1ns/1ps
`include "bdm_map.vh"
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
  reg  mclk = 1'b0, nrst = 1'b0, wdtSleepRst = 1'b0, aluWb = 1'b0;
  reg  aluFlagEn = 1'b0, aluCarryEn = 1'b0, aluCarry = 1'b0, aluZero = 1'b0;
  reg  aluNibbleCarry = 1'b0, aluOverflow = 1'b0, haltInstr = 1'b0;
  reg  watchdogClearInstr = 1'b0, watchdogExpired = 1'b0, tableLoad = 1'b0;
  reg  accLoad = 1'b0;
  reg  [7:0] tableHighIn = 8'h00, accIn = 8'h00, rdv, a, d;
  reg  [5:0] f;
  reg  [3:0] old;
  wire [7:0] memAddr, memWrData, memRdData, accumulatorReg, pointerZero;
  wire [7:0] pointerOne, dataBankSelect, programCounterLow, tableLowPtr;
  wire [7:0] tableHighPtr, tableHighByte, statusReg, lcdData;
  wire [3:0] eepromControlReg;
  wire [4:0] lcdAddr;
  wire       memRd, memWr, pcJump, dummyCycle, lcdWr;
  int        errors = 0, compares = 0;
  reg  [2:0] sbv [5] = '{3'b100, 3'b001, 3'b010, 3'b001, 3'b100};
  reg  [7:0] sbx [5] = '{8'h1f, 8'h3f, 8'h0f, 8'h2f, 8'h1f};
  bdm_data_memory u_dut (.*);
  bdm_core_model u_core (.*);
  always #5 mclk = ~mclk;
  function [3:0] flagsExp(input [3:0] o, input [5:0] v);
    flagsExp = v[5] ? v[3:0] : v[4] ? {o[3:1], v[0]} : o;
  endfunction
  task sb(input [2:0] s);
    @(negedge mclk) {haltInstr, watchdogClearInstr, watchdogExpired} = s;
    @(negedge mclk) {haltInstr, watchdogClearInstr, watchdogExpired} = 3'b0;
  endtask
  task test_done();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // whole run is a few hundred cycles; forty times that margin
  initial begin
    #100000;
    errors++;
    test_done();
  end
  initial begin
    void'($urandom(41404));
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    `CHK("status", 8'h00, statusReg)
    `CHK("bank", 8'h00, dataBankSelect)
    for (int b = 0; b <= 4; b++) begin
      u_core.wr(`BDM_OFF_BANKSEL, {5'h1f, b[2:0]});
      u_core.rd(`BDM_OFF_BANKSEL, rdv);
      `CHK("banksel", {5'h00, b[2:0]}, rdv)
    end
    u_core.wr(`BDM_OFF_BANKSEL, 8'h02);
    for (int i = 0; i < 8; i++) begin
      a = 8'h80 | 8'($urandom);
      d = 8'($urandom);
      u_core.wr(a, d);
      u_core.wr(`BDM_OFF_PTR1, a);
      u_core.wr(`BDM_OFF_WIN1, ~d);
      u_core.wr(`BDM_OFF_PTR0, a);
      u_core.rd(`BDM_OFF_WIN0, rdv);
      `CHK("win0", d, rdv)
      u_core.rd(a, rdv);
      `CHK("direct", d, rdv)
      u_core.rd(`BDM_OFF_WIN1, rdv);
      `CHK("win1", ~d, rdv)
    end
    u_core.wr(`BDM_OFF_PTR0, `BDM_OFF_WIN1);
    u_core.wr(`BDM_OFF_WIN0, 8'h5a);
    u_core.rd(`BDM_OFF_WIN0, rdv);
    `CHK("winwin", 8'h00, rdv)
    `CHK("ptr0", `BDM_OFF_WIN1, pointerZero)
    u_core.rd(`BDM_OFF_WIN1, rdv);
    `CHK("winwr", ~d, rdv)
    repeat (4) begin
      u_core.rd(8'h0b + 8'($urandom_range(52)), rdv);
      `CHK("unused", 8'h00, rdv)
    end
    u_core.rd(`BDM_OFF_EECTRL, rdv);
    `CHK("eec direct", 8'h00, rdv)
    u_core.wr(`BDM_OFF_BANKSEL, 8'h01);
    u_core.wr(`BDM_OFF_PTR1, `BDM_OFF_EECTRL);
    u_core.wr(`BDM_OFF_WIN1, 8'h0a);
    `CHK("eec", 4'ha, eepromControlReg)
    u_core.wr(`BDM_OFF_BANKSEL, 8'h04);
    u_core.wr(`BDM_OFF_PTR1, `BDM_LCD_LAST);
    u_core.wr(`BDM_OFF_WIN1, 8'hc3);
    `CHK("lcdWr", 1'b1, lcdWr)
    `CHK("lcdAddr", 5'h15, lcdAddr)
    `CHK("lcdData", 8'hc3, lcdData)
    @(negedge mclk) wdtSleepRst = 1'b1;
    @(negedge mclk) wdtSleepRst = 1'b0;
    `CHK("bank kept", 8'h04, dataBankSelect)
    u_core.wr(`BDM_OFF_PCLOW, 8'h3c);
    `CHK("pcJump", 1'b1, pcJump)
    `CHK("pcl", 8'h3c, programCounterLow)
    @(negedge mclk);
    `CHK("dummy", 1'b1, dummyCycle)
    d = 8'($urandom);
    @(negedge mclk) {tableHighIn, tableLoad, accIn, accLoad} = {d, 1'b1, ~d, 1'b1};
    @(negedge mclk) {tableLoad, accLoad} = 2'b00;
    `CHK("table_high_byte", d, tableHighByte)
    `CHK("acc", ~d, accumulatorReg)
    u_core.wr(`BDM_OFF_TBLLO, 8'hff);
    `CHK("tblp", 8'hff, tableLowPtr)
    u_core.wr(`BDM_OFF_TBLHIPTR, 8'h5a);
    `CHK("tbhp", 8'h5a, tableHighPtr)
    u_core.wr(`BDM_OFF_STATUS, 8'hff);
    `CHK("st wr", 8'h0f, statusReg)
    for (int i = 0; i < 5; i++) begin
      sb(sbv[i]);
      `CHK("sys", sbx[i], statusReg)
    end
    for (int i = 0; i < 24; i++) begin
      f = 6'($urandom);
      old = statusReg[3:0];
      @(negedge mclk) aluWb = 1'b1;
      {aluFlagEn, aluCarryEn, aluOverflow, aluZero} = f[5:2];
      {aluNibbleCarry, aluCarry} = f[1:0];
      @(negedge mclk) aluWb = 1'b0;
      `CHK("flags", flagsExp(old, f), statusReg[3:0])
    end
    @(negedge mclk) nrst = 1'b0;
    @(negedge mclk) nrst = 1'b1;
    `CHK("bank reset", 8'h00, dataBankSelect)
    test_done();
  end
endmodule // tb_top
